// ===== usia_pkg.sv
// Constants for the USB streaming interrupt aggregator
package usia_pkg;
	// Register byte offsets
	localparam logic [7:0] OFF_USB_STATUS = 8'h00;
	localparam logic [7:0] OFF_USB_CONTROL = 8'h04;
	localparam logic [7:0] OFF_INT_MASK = 8'h08;
	localparam logic [7:0] OFF_PENDING = 8'h0C;
	localparam logic [7:0] OFF_INT_VECTOR = 8'h10;
	localparam logic [7:0] OFF_CODEC_ADDR = 8'h14;
	localparam logic [7:0] OFF_CODEC_DATA_LOW = 8'h18;
	localparam logic [7:0] OFF_CODEC_DATA_HIGH = 8'h1C;
	localparam logic [7:0] OFF_CODEC_CTRL_STATUS = 8'h20;
	// Source numbers (pending and mask bit positions)
	localparam int NUM_SRC = 30;
	localparam int SRC_IN_EP = 0;
	localparam int SRC_OUT_EP = 8;
	localparam int SRC_BUS_RESET = 16;
	localparam int SRC_SUSPEND = 17;
	localparam int SRC_RESUME = 18;
	localparam int SRC_SOF = 19;
	localparam int SRC_MISSED_SOF = 20;
	localparam int SRC_SETUP = 21;
	localparam int SRC_SETUP_OVR = 22;
	localparam int SRC_CODEC_TX = 23;
	localparam int SRC_CODEC_RX = 24;
	localparam int SRC_I2C_TX = 25;
	localparam int SRC_I2C_RX = 26;
	localparam int SRC_DMA0 = 27;
	localparam int SRC_DMA1 = 28;
	localparam int SRC_EXT = 29;
	localparam logic [4:0] VECTOR_NONE = 5'h1F;
	// Control bit positions
	localparam int CTL_FUNC_RESET_GLOBAL_EN = 0;
	localparam int CTL_PORT3_BIT_THREE_GPIO = 1;
	localparam int CODEC_RW_BIT = 7;
	localparam int CS_TX_EMPTY = 0;
	localparam int CS_RX_FULL = 1;
	// Reset values
	localparam logic [1:0] USB_CONTROL_RESET = 2'h0;
	localparam logic [29:0] INT_MASK_RESET = 30'h00000000;
	// Timing
	localparam int CLK_HZ = 40000000;
	localparam int SUSPEND_IDLE_MS = 5;
	localparam int FRAME_PERIOD_MS = 1;
	localparam int SUSPEND_CYCLES = CLK_HZ / 1000 * SUSPEND_IDLE_MS;
	localparam int FRAME_CYCLES = CLK_HZ / 1000 * FRAME_PERIOD_MS;
	localparam logic [3:0] GLOBAL_RESET_CYCLES = 4'hF;
	// Codec secondary transfer states
	typedef enum logic [3:0] {
		CS_IDLE = 4'b0001,
		CS_ADDR = 4'b0010,
		CS_WAIT_TAKEN = 4'b0100,
		CS_WAIT_DATA = 4'b1000
	} usia_codec_state_type;
endpackage

// ===== usia_aggregator.sv
// Interrupt aggregation, USB event status and codec secondary handshake
module usia_aggregator #(
	parameter int SUSPEND_CYCLES = usia_pkg::SUSPEND_CYCLES,
	parameter int FRAME_CYCLES = usia_pkg::FRAME_CYCLES,
	parameter int CNT_W = 18
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [7:0] inEpAck,
	input wire logic [7:0] inEpIso,
	input wire logic [7:0] outEpStored,
	input wire logic [7:0] outEpIso,
	input wire logic usbBusReset,
	input wire logic busIdleJ,
	input wire logic sofReceived,
	input wire logic setupOk,
	input wire logic i2cTxEmptyEvent,
	input wire logic i2cRxFullEvent,
	input wire logic dma0Done,
	input wire logic dma1Done,
	input wire logic externalRequestN,
	input wire logic port3BitThree,
	input wire logic codecFrameStart,
	input wire logic codecTxTaken,
	input wire logic codecRxValid,
	input wire logic [15:0] codecRxData,
	output logic codecCmdValid,
	output logic codecCmdRead,
	output logic [6:0] codecCmdAddr,
	output logic [15:0] codecCmdData,
	output logic coreExtIrqPrimary,
	output logic coreExtIrqSecondary,
	output logic port3BitThreeGpio,
	output logic usbLogicReset,
	output logic resetOutput
);
	logic [29:0] pending;
	logic [29:0] intMask;
	logic [1:0] usbControl;
	logic [7:0] codecAddress;
	logic [7:0] codecDataLow;
	logic [7:0] codecDataHigh;
	logic txHoldingEmpty;
	logic rxHoldingFull;
	logic suspended;
	logic [CNT_W-1:0] idleCnt;
	logic [CNT_W-1:0] frameCnt;
	logic [3:0] globalCnt;
	logic extSync1;
	logic extSync2;
	logic extPrev;
	logic [4:0] vectorRead;
	usia_pkg::usia_codec_state_type codecState;
	usia_pkg::usia_codec_state_type next_codecState;

	// Bus decode
	wire logic setupPhase = psel & ~penable;
	wire logic accessPhase = psel & penable;
	wire logic wrTaken = accessPhase & pwrite;
	wire logic rdTaken = accessPhase & ~pwrite;
	wire logic hitStatus = paddr == usia_pkg::OFF_USB_STATUS;
	wire logic hitControl = paddr == usia_pkg::OFF_USB_CONTROL;
	wire logic hitMask = paddr == usia_pkg::OFF_INT_MASK;
	wire logic hitPending = paddr == usia_pkg::OFF_PENDING;
	wire logic hitVector = paddr == usia_pkg::OFF_INT_VECTOR;
	wire logic hitAddr = paddr == usia_pkg::OFF_CODEC_ADDR;
	wire logic hitLow = paddr == usia_pkg::OFF_CODEC_DATA_LOW;
	wire logic hitHigh = paddr == usia_pkg::OFF_CODEC_DATA_HIGH;
	wire logic hitCs = paddr == usia_pkg::OFF_CODEC_CTRL_STATUS;
	wire logic mapped = hitStatus | hitControl | hitMask | hitPending | hitVector | hitAddr | hitLow | hitHigh | hitCs;
	wire logic addrWrite = wrTaken & hitAddr;
	wire logic lowRead = rdTaken & hitLow;
	wire logic globalReset = globalCnt != 4'h0;
	wire logic [6:0] usbStatus = pending[usia_pkg::SRC_SETUP_OVR:usia_pkg::SRC_BUS_RESET];

	// Vector write clears one latch
	wire logic vectorWrite = wrTaken & hitVector;
	wire logic [29:0] clearVec = vectorWrite ? 30'(1) << pwdata[4:0] : 30'h00000000;

	wire logic extFall = extPrev & ~extSync2;

	wire logic resetToGlobal = usbBusReset & usbControl[usia_pkg::CTL_FUNC_RESET_GLOBAL_EN];
	wire logic resetToIrq = usbBusReset & ~usbControl[usia_pkg::CTL_FUNC_RESET_GLOBAL_EN];

	wire logic suspendEvt = busIdleJ & ~suspended & (idleCnt == CNT_W'(SUSPEND_CYCLES));
	wire logic resumeEvt = suspended & ~busIdleJ;
	wire logic missedEvt = ~sofReceived & (frameCnt == CNT_W'(FRAME_CYCLES - 1));
	wire logic setupEvt = setupOk & ~pending[usia_pkg::SRC_SETUP];
	wire logic overrunEvt = setupOk & pending[usia_pkg::SRC_SETUP];
	wire logic txDoneEvt = codecTxTaken & (codecState == usia_pkg::CS_WAIT_TAKEN);

	wire logic [29:0] setVec = {
		extFall, dma1Done, dma0Done, i2cRxFullEvent, i2cTxEmptyEvent,
		codecRxValid, txDoneEvt,
		overrunEvt, setupEvt, missedEvt, sofReceived, resumeEvt, suspendEvt, resetToIrq,
		outEpStored & ~outEpIso,
		inEpAck & ~inEpIso
	};

	assign coreExtIrqPrimary = |(pending & intMask);
	assign coreExtIrqSecondary = usbControl[usia_pkg::CTL_PORT3_BIT_THREE_GPIO] ? 1'b1 : port3BitThree;
	assign port3BitThreeGpio = port3BitThree;
	assign pready = 1'b1;
	assign pslverr = accessPhase & ~mapped;

	// Lowest unmasked pending source
	always_comb begin
		vectorRead = usia_pkg::VECTOR_NONE;
		for (int i = usia_pkg::NUM_SRC - 1; i >= 0; i--) begin
			if (pending[i] & intMask[i]) begin
				vectorRead = 5'(i);
			end
		end
	end

	wire logic [31:0] rdMux =
		hitStatus ? {25'h0, usbStatus} :
		hitControl ? {30'h0, usbControl} :
		hitMask ? {2'h0, intMask} :
		hitPending ? {2'h0, pending} :
		hitVector ? {27'h0, vectorRead} :
		hitAddr ? {24'h0, codecAddress} :
		hitLow ? {24'h0, codecDataLow} :
		hitHigh ? {24'h0, codecDataHigh} :
		hitCs ? {30'h0, rxHoldingFull, txHoldingEmpty} : 32'h00000000;

	// Codec secondary sequencing
	always_comb begin
		next_codecState = codecState;
		unique case (codecState)
			usia_pkg::CS_IDLE: begin
				if (addrWrite) begin
					next_codecState = usia_pkg::CS_ADDR;
				end
			end
			usia_pkg::CS_ADDR: begin
				if (codecFrameStart) begin
					next_codecState = codecAddress[usia_pkg::CODEC_RW_BIT] ? usia_pkg::CS_WAIT_DATA : usia_pkg::CS_WAIT_TAKEN;
				end
			end
			usia_pkg::CS_WAIT_TAKEN: begin
				if (codecTxTaken) begin
					next_codecState = usia_pkg::CS_IDLE;
				end
			end
			usia_pkg::CS_WAIT_DATA: begin
				if (codecRxValid) begin
					next_codecState = usia_pkg::CS_IDLE;
				end
			end
			default: begin
				next_codecState = usia_pkg::CS_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			codecState <= usia_pkg::CS_IDLE;
			codecCmdValid <= 1'b0;
			codecCmdRead <= 1'b0;
			codecCmdAddr <= 7'h00;
			codecCmdData <= 16'h0000;
		end else begin
			codecState <= next_codecState;
			codecCmdValid <= (codecState == usia_pkg::CS_ADDR) & codecFrameStart;
			if ((codecState == usia_pkg::CS_ADDR) & codecFrameStart) begin
				codecCmdRead <= codecAddress[usia_pkg::CODEC_RW_BIT];
				codecCmdAddr <= codecAddress[6:0];
				codecCmdData <= {codecDataHigh, codecDataLow};
			end
		end
	end

	// Codec registers and flags
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			codecAddress <= 8'h00;
			codecDataLow <= 8'h00;
			codecDataHigh <= 8'h00;
			txHoldingEmpty <= 1'b1;
			rxHoldingFull <= 1'b0;
		end else begin
			if (addrWrite && codecState == usia_pkg::CS_IDLE) begin
				codecAddress <= pwdata[7:0];
			end
			if (codecRxValid) begin
				codecDataLow <= codecRxData[7:0];
				codecDataHigh <= codecRxData[15:8];
			end else begin
				if (wrTaken & hitLow) begin
					codecDataLow <= pwdata[7:0];
				end
				if (wrTaken & hitHigh) begin
					codecDataHigh <= pwdata[7:0];
				end
			end
			if (txDoneEvt) begin
				txHoldingEmpty <= 1'b1;
			end else if (addrWrite && codecState == usia_pkg::CS_IDLE && !pwdata[usia_pkg::CODEC_RW_BIT]) begin
				txHoldingEmpty <= 1'b0;
			end
			if (codecRxValid) begin
				rxHoldingFull <= 1'b1;
			end else if (lowRead) begin
				rxHoldingFull <= 1'b0;
			end
		end
	end

	// Control, mask and bus read data
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			usbControl <= usia_pkg::USB_CONTROL_RESET;
			intMask <= usia_pkg::INT_MASK_RESET;
			prdata <= 32'h00000000;
		end else begin
			if (wrTaken & hitControl) begin
				usbControl <= pwdata[1:0];
			end
			if (wrTaken & hitMask) begin
				intMask <= pwdata[29:0];
			end
			if (setupPhase & ~pwrite) begin
				prdata <= rdMux;
			end
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			pending <= 30'h00000000;
		end else if (globalReset) begin
			pending <= 30'h00000000;
		end else begin
			pending <= (pending & ~clearVec) | setVec;
		end
	end

	// Global reset, USB logic reset, suspend and frame timing
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			globalCnt <= 4'h0;
			resetOutput <= 1'b0;
			usbLogicReset <= 1'b0;
			suspended <= 1'b0;
			idleCnt <= '0;
			frameCnt <= '0;
			extSync1 <= 1'b1;
			extSync2 <= 1'b1;
			extPrev <= 1'b1;
		end else begin
			extSync1 <= externalRequestN;
			extSync2 <= extSync1;
			extPrev <= extSync2;
			if (resetToGlobal) begin
				globalCnt <= usia_pkg::GLOBAL_RESET_CYCLES;
			end else if (globalReset) begin
				globalCnt <= globalCnt - 4'h1;
			end
			resetOutput <= resetToGlobal | (globalCnt > 4'h1);
			usbLogicReset <= usbBusReset;
			if (usbBusReset | resumeEvt) begin
				suspended <= 1'b0;
			end else if (suspendEvt) begin
				suspended <= 1'b1;
			end
			if (!busIdleJ || suspended) begin
				idleCnt <= '0;
			end else if (idleCnt != CNT_W'(SUSPEND_CYCLES)) begin
				idleCnt <= idleCnt + CNT_W'(1);
			end
			if (sofReceived || missedEvt) begin
				frameCnt <= '0;
			end else begin
				frameCnt <= frameCnt + CNT_W'(1);
			end
		end
	end

	// Checks
	property p_ext_edge;
		@(posedge clock) disable iff (!nrst) extPrev && !extSync2 && !globalReset |=> pending[usia_pkg::SRC_EXT];
	endproperty
	a_ext_edge: assert property (p_ext_edge) else $error("external edge not latched");
	property p_ext_once;
		@(posedge clock) disable iff (!nrst)
			!extSync2 && !extPrev && vectorWrite && pwdata[4:0] == 5'h1D |=> !pending[usia_pkg::SRC_EXT];
	endproperty
	a_ext_once: assert property (p_ext_once) else $error("held request retriggered");
	property p_setup_ovr;
		@(posedge clock) disable iff (!nrst)
			setupOk && pending[usia_pkg::SRC_SETUP] && !globalReset |=> pending[usia_pkg::SRC_SETUP_OVR];
	endproperty
	a_setup_ovr: assert property (p_setup_ovr) else $error("setup overrun missed");
	property p_tx_done;
		@(posedge clock) disable iff (!nrst)
			codecTxTaken && codecState == usia_pkg::CS_WAIT_TAKEN && !globalReset
			|=> txHoldingEmpty && pending[usia_pkg::SRC_CODEC_TX];
	endproperty
	a_tx_done: assert property (p_tx_done) else $error("tx empty not raised");
	property p_addr_clear;
		@(posedge clock) disable iff (!nrst)
			addrWrite && codecState == usia_pkg::CS_IDLE && !pwdata[7] |=> !txHoldingEmpty && codecState == usia_pkg::CS_ADDR;
	endproperty
	a_addr_clear: assert property (p_addr_clear) else $error("tx empty not cleared");
	property p_rx_clear;
		@(posedge clock) disable iff (!nrst) lowRead && !codecRxValid |=> !rxHoldingFull;
	endproperty
	a_rx_clear: assert property (p_rx_clear) else $error("rx full not cleared");
	property p_global;
		@(posedge clock) disable iff (!nrst) resetToGlobal |=> resetOutput ##1 usbStatus == 7'h00;
	endproperty
	a_global: assert property (p_global) else $error("global reset failed");
	property p_func_irq;
		@(posedge clock) disable iff (!nrst)
			resetToIrq && !globalReset |=> pending[usia_pkg::SRC_BUS_RESET];
	endproperty
	a_func_irq: assert property (p_func_irq) else $error("function reset irq missing");
	property p_iso_in;
		@(posedge clock) disable iff (!nrst) inEpAck[0] && inEpIso[0] && !pending[0] |=> !pending[0];
	endproperty
	a_iso_in: assert property (p_iso_in) else $error("isochronous IN raised irq");
	property p_vec_clear;
		@(posedge clock) disable iff (!nrst)
			vectorWrite && pwdata[4:0] == 5'h13 && !sofReceived |=> !pending[usia_pkg::SRC_SOF];
	endproperty
	a_vec_clear: assert property (p_vec_clear) else $error("vector clear ignored");
	c_suspend: cover property (@(posedge clock) disable iff (!nrst) suspendEvt ##[1:20] resumeEvt);
	c_read_xfer: cover property (@(posedge clock) disable iff (!nrst)
		codecState == usia_pkg::CS_WAIT_DATA ##1 codecRxValid);
	c_missed: cover property (@(posedge clock) disable iff (!nrst) missedEvt);
	c_irq: cover property (@(posedge clock) disable iff (!nrst) $rose(coreExtIrqPrimary));
endmodule

// ===== usia_codec_model.sv
// Codec-side model answering secondary commands frame by frame
module usia_codec_model (
	input wire logic clock,
	input wire logic nrst,
	input wire logic codecCmdValid,
	input wire logic codecCmdRead,
	input wire logic [6:0] codecCmdAddr,
	output logic codecFrameStart,
	output logic codecTxTaken,
	output logic codecRxValid,
	output logic [15:0] codecRxData
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] tick;
	logic [15:0] noise;
	logic [6:0] addr;
	logic wantTx;
	logic wantRx;
	assign codecFrameStart = (tick == 4'hF);
	// Data line changes every cycle outside a reply
	assign codecRxData = codecRxValid ? {addr, 1'b1, addr, 1'b0} : noise;
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			tick <= 4'h0;
			noise <= 16'h0000;
			addr <= 7'h00;
			wantTx <= 1'b0;
			wantRx <= 1'b0;
			codecTxTaken <= 1'b0;
			codecRxValid <= 1'b0;
		end else begin
			tick <= tick + 4'h1;
			noise <= noise + 16'h3B1D;
			codecTxTaken <= 1'b0;
			codecRxValid <= 1'b0;
			if (codecCmdValid) begin
				wantTx <= !codecCmdRead;
				wantRx <= codecCmdRead;
				addr <= codecCmdAddr;
			end else if (codecFrameStart && wantTx) begin
				codecTxTaken <= 1'b1;
				wantTx <= 1'b0;
			end else if (codecFrameStart && wantRx) begin
				codecRxValid <= 1'b1;
				wantRx <= 1'b0;
			end
		end
	end
endmodule

// ===== usia_aggregator_bench.sv
// Self-checking bench for the interrupt aggregator
module usia_aggregator_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 1'b0;
	logic nrst = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [22:0] evt = 23'h000000;
	logic [7:0] inEpIso = 8'h00;
	logic [7:0] outEpIso = 8'h00;
	logic busIdleJ = 1'b0;
	logic externalRequestN = 1'b1;
	logic port3BitThree = 1'b0;
	logic [31:0] seed = 32'h00009428;
	logic [31:0] prdata, rdv, r, mask;
	logic pready, pslverr, frameStart, txTaken, rxValid, cmdValid, cmdRead, irq1, irq2, gpio, usbRst, rstOut, err;
	logic [15:0] rxData, cmdData;
	logic [6:0] cmdAddr;
	logic [29:0] expPend;
	int fails = 0;
	int cmpCount = 0;
	int cyc = 0;
	int nl, nr;
	always #12.5 clock = ~clock;
	usia_aggregator #(.SUSPEND_CYCLES(50), .FRAME_CYCLES(100), .CNT_W(18)) DUT (
		.clock(clock), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .inEpAck(evt[7:0]),
		.inEpIso(inEpIso), .outEpStored(evt[15:8]), .outEpIso(outEpIso), .usbBusReset(evt[16]),
		.busIdleJ(busIdleJ), .sofReceived(evt[17]), .setupOk(evt[18]), .i2cTxEmptyEvent(evt[19]),
		.i2cRxFullEvent(evt[20]), .dma0Done(evt[21]), .dma1Done(evt[22]), .externalRequestN(externalRequestN),
		.port3BitThree(port3BitThree), .codecFrameStart(frameStart), .codecTxTaken(txTaken),
		.codecRxValid(rxValid), .codecRxData(rxData), .codecCmdValid(cmdValid), .codecCmdRead(cmdRead),
		.codecCmdAddr(cmdAddr), .codecCmdData(cmdData), .coreExtIrqPrimary(irq1), .coreExtIrqSecondary(irq2),
		.port3BitThreeGpio(gpio), .usbLogicReset(usbRst), .resetOutput(rstOut));
	usia_codec_model codec (.clock(clock), .nrst(nrst), .codecCmdValid(cmdValid), .codecCmdRead(cmdRead),
		.codecCmdAddr(cmdAddr), .codecFrameStart(frameStart), .codecTxTaken(txTaken), .codecRxValid(rxValid),
		.codecRxData(rxData));
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic printVerdict();
		$display("comparisons %0d mismatches %0d", cmpCount, fails);
		if (fails == 0 && cmpCount > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		cmpCount++;
		if (s !== e) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		rdv = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask
	task automatic clr(input int s);
		apb(1'b1, 8'h10, s);
		expPend[s] = 1'b0;
	endtask
	task automatic fire(input logic [22:0] v);
		evt <= v;
		@(posedge clock);
		evt <= 23'h000000;
		@(posedge clock);
	endtask
	task automatic chkPend(input string n);
		int lo;
		lo = 31;
		for (int i = 29; i >= 0; i--) if (expPend[i] && mask[i]) lo = i;
		apb(1'b0, 8'h0C, 32'h0);
		chk(n, {2'b00, expPend} & 32'h3FE7FFFF, rdv & 32'h3FE7FFFF);
		apb(1'b0, 8'h00, 32'h0);
		chk("status", {25'h0, expPend[22:16]} & 32'h67, rdv & 32'h67);
		apb(1'b0, 8'h10, 32'h0);
		chk("vector", lo, rdv);
		@(negedge clock);
		chk("irq", |(expPend & mask[29:0]), irq1);
		@(posedge clock);
	endtask
	task automatic busRst();
		nl = 0;
		nr = 0;
		evt <= 23'h010000;
		repeat (24) begin
			@(posedge clock);
			evt <= 23'h000000;
			@(negedge clock);
			nl += usbRst;
			nr += rstOut;
		end
		@(posedge clock);
	endtask
	task automatic waitCmd(input logic [23:0] e, input logic [23:0] m);
		for (int i = 0; i < 40 && cmdValid !== 1'b1; i++) @(negedge clock);
		chk("commandValid", 1, cmdValid);
		chk("command", e & m, {cmdRead, cmdAddr, cmdData} & m);
		@(posedge clock);
	endtask
	task automatic poll(input int b);
		for (int i = 0; i < 12; i++) begin
			apb(1'b0, 8'h20, 32'h0);
			if (rdv[b] === 1'b1) break;
		end
	endtask
	always @(posedge clock) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			printVerdict();
		end
	end
	initial begin
		expPend = 30'h0;
		mask = 32'h3FE7FFFF;
		repeat (6) @(posedge clock);
		nrst <= 1'b1;
		@(posedge clock);
		chkPend("pendingReset");
		apb(1'b0, 8'h20, 32'h0);
		chk("codecStatusReset", 32'h1, rdv);
		apb(1'b0, 8'h40, 32'h0);
		chk("unmappedErr", 32'h1, err);
		apb(1'b1, 8'h08, mask);
		apb(1'b0, 8'h08, 32'h0);
		chk("maskReadback", mask, rdv);
		repeat (6) begin
			rdv = rnd();
			inEpIso <= rdv[7:0];
			outEpIso <= rdv[15:8];
			fire({7'h00, rdv[23:16], rdv[31:24]});
			expPend[15:0] = expPend[15:0] | ({rdv[23:16], rdv[31:24]} & ~rdv[15:0]);
			chkPend("endpoint");
		end
		apb(1'b1, 8'h08, 32'h0);
		mask = 32'h0;
		chkPend("masked");
		mask = 32'h3FE7FFFF;
		apb(1'b1, 8'h08, mask);
		for (int s = 0; s < 16; s++) clr(s);
		chkPend("endpointCleared");
		fire(23'h040000);
		expPend[21] = 1'b1;
		chkPend("setup");
		fire(23'h040000);
		expPend[22] = 1'b1;
		chkPend("setupOverrun");
		fire(23'h020000);
		clr(19);
		clr(20);
		apb(1'b0, 8'h0C, 32'h0);
		chk("frameCleared", 2'b00, rdv[20:19]);
		fire(23'h020000);
		apb(1'b0, 8'h0C, 32'h0);
		chk("frameStart", 2'b01, rdv[20:19]);
		repeat (105) @(posedge clock);
		apb(1'b0, 8'h0C, 32'h0);
		chk("frameMissed", 2'b11, rdv[20:19]);
		busIdleJ <= 1'b1;
		repeat (40) @(posedge clock);
		chkPend("idleShort");
		repeat (8) @(posedge clock);
		expPend[17] = 1'b1;
		chkPend("suspend");
		busIdleJ <= 1'b0;
		repeat (3) @(posedge clock);
		expPend[18] = 1'b1;
		chkPend("resume");
		for (int s = 17; s < 23; s++) clr(s);
		chkPend("usbCleared");
		busRst();
		chk("usbLogicReset", 1, nl);
		chk("noGlobalReset", 0, nr);
		expPend[16] = 1'b1;
		chkPend("busReset");
		fire(23'h780000);
		expPend[28:25] = 4'hF;
		chkPend("i2cDma");
		apb(1'b1, 8'h04, 32'h1);
		busRst();
		chk("globalResetLength", 15, nr);
		expPend = 30'h0;
		chkPend("globalCleared");
		apb(1'b1, 8'h04, 32'h0);
		for (int k = 0; k < 2; k++) begin
			externalRequestN <= 1'b0;
			repeat (8) @(posedge clock);
			expPend[29] = 1'b1;
			chkPend("external");
			clr(29);
			repeat (8) @(posedge clock);
			chkPend("externalHeld");
			externalRequestN <= 1'b1;
			repeat (4) @(posedge clock);
		end
		r = rnd();
		apb(1'b1, 8'h18, {24'h0, r[7:0]});
		apb(1'b1, 8'h1C, {24'h0, r[15:8]});
		apb(1'b1, 8'h14, {24'h0, 1'b0, r[22:16]});
		waitCmd({1'b0, r[22:0]}, 24'hFFFFFF);
		apb(1'b0, 8'h20, 32'h0);
		chk("txBusy", 32'h0, rdv);
		poll(0);
		chk("txEmpty", 32'h1, rdv);
		expPend[23] = 1'b1;
		chkPend("codecTx");
		clr(23);
		apb(1'b0, 8'h20, 32'h0);
		chk("txKept", 32'h1, rdv);
		apb(1'b1, 8'h14, {24'h0, 1'b1, r[30:24]});
		waitCmd({1'b1, r[30:24], 16'h0}, 24'hFF0000);
		poll(1);
		chk("rxFull", 32'h3, rdv);
		expPend[24] = 1'b1;
		chkPend("codecRx");
		clr(24);
		apb(1'b0, 8'h20, 32'h0);
		chk("rxKept", 32'h3, rdv);
		apb(1'b0, 8'h1C, 32'h0);
		chk("rxHigh", {24'h0, r[30:24], 1'b1}, rdv);
		apb(1'b0, 8'h18, 32'h0);
		chk("rxLow", {24'h0, r[30:24], 1'b0}, rdv);
		apb(1'b0, 8'h20, 32'h0);
		chk("rxRead", 32'h1, rdv);
		port3BitThree <= 1'b1;
		@(negedge clock);
		chk("secondaryHigh", 2'b11, {irq2, gpio});
		@(posedge clock);
		port3BitThree <= 1'b0;
		@(negedge clock);
		chk("secondary", 0, {irq2, gpio});
		@(posedge clock);
		apb(1'b1, 8'h04, 32'h2);
		@(negedge clock);
		chk("secondaryGpio", 32'h1, irq2);
		@(posedge clock);
		printVerdict();
	end
endmodule
